/* logic/ext_sub_sum_alu.v */
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module ext_sub_sum_alu (
    input  wire                 CLOCK,
    input  wire                 RST,
    input  wire [`ADDR_W-1:0]   ADDR,
    input  wire [`DATA_W-1:0]   WDATA,
    input  wire                 WRITE,
    input  wire                 READ,
    output reg  [`DATA_W-1:0]   RDATA,
    output wire                 BUSY,
    output reg                  DONE,
    output reg                  ZERO_FLAG,
    output reg                  CARRY_FLAG
);

// ---------------------------------------------
// States
// ---------------------------------------------
// One instruction occupies four clocks: read, compute, settle, retire
localparam [2:0] S_IDLE  = 3'h0;
localparam [2:0] S_READ  = 3'h1;
localparam [2:0] S_CALC  = 3'h2;
localparam [2:0] S_CHECK = 3'h3;
localparam [2:0] S_WRITE = 3'h4;

// ---------------------------------------------
// Storage
// ---------------------------------------------
// Register file lives here; it has no reset, software loads it
reg [`DATA_W-1:0] regs [0:(1<<`IDX_W)-1];

reg [2:0]           state;
reg [2:0]           next_state;
reg [`DATA_W-1:0]   instr;
reg [`DATA_W-1:0]   dest_value;
reg [`DATA_W-1:0]   src_value;
reg [`DATA_W-1:0]   result_value;
reg                 zero_result;
reg                 carry_result;
reg                 op_known;
reg                 cond_pass;
reg [`DATA_W-1:0]   last_result;
reg [`DATA_W-1:0]   retired;
reg                 illegal;
reg                 refused;
reg                 skipped;

// ---------------------------------------------
// Decode of the held instruction
// ---------------------------------------------
wire [5:0]          opcode;
wire                want_zero;
wire                want_carry;
wire                want_result;
wire                immediate;
wire [3:0]          cond;
wire [`IDX_W-1:0]   dest_idx;
wire [`IDX_W-1:0]   src_field;

assign opcode      = instr[`INSTR_OPCODE];
assign want_zero   = instr[`BIT_UPD_Z];
assign want_carry  = instr[`BIT_UPD_C];
assign want_result = instr[`BIT_WR];
assign immediate   = instr[`BIT_IMM];
assign cond        = instr[`INSTR_COND];
assign dest_idx    = instr[`INSTR_DEST];
assign src_field   = instr[`INSTR_SRC];

// ---------------------------------------------
// Bus decode
// ---------------------------------------------
wire to_file;
wire write_file;
wire write_flags;
wire write_instr;
wire write_status;
wire write_count;

assign to_file      = ~ADDR[`ADDR_FILE_BIT];
assign write_file   = WRITE & to_file;
assign write_flags  = WRITE & (ADDR == `ADDR_FLAGS);
assign write_instr  = WRITE & (ADDR == `ADDR_INSTR);
assign write_status = WRITE & (ADDR == `ADDR_STATUS);
assign write_count  = WRITE & (ADDR == `ADDR_COUNT);

assign BUSY = (state != S_IDLE);

// ---------------------------------------------
// Operand path
// ---------------------------------------------
wire [`DATA_W-1:0]  src_operand;
wire [`DATA_W-1:0]  core_result;
wire                core_zero;
wire                core_carry;
wire                core_known;

literal_source_select u_source (
    .immediate (immediate),
    .src_field (src_field),
    .reg_value (regs[src_field]),
    .operand   (src_operand)
);

sub_sum_core u_core (
    .opcode    (opcode),
    .dest      (dest_value),
    .src       (src_value),
    .zero_in   (ZERO_FLAG),
    .carry_in  (CARRY_FLAG),
    .result    (core_result),
    .zero_out  (core_zero),
    .carry_out (core_carry),
    .known     (core_known)
);

// ---------------------------------------------
// Sequencer
// ---------------------------------------------
always @* begin
    next_state = state;
    case (state)
        S_IDLE: begin
            if (write_instr)
                next_state = S_READ;
        end
        S_READ: begin
            next_state = S_CALC;
        end
        S_CALC: begin
            next_state = S_CHECK;
        end
        S_CHECK: begin
            next_state = S_WRITE;
        end
        S_WRITE: begin
            next_state = S_IDLE;
        end
        default: begin
            next_state = S_IDLE;
        end
    endcase
end

always @(posedge CLOCK) begin
    if (RST)
        state <= S_IDLE;
    else
        state <= next_state;
end

// ---------------------------------------------
// Datapath pipeline
// ---------------------------------------------
// Operands are sampled once so bus writes cannot disturb a running op
always @(posedge CLOCK) begin
    if (RST) begin
        instr        <= `ZERO_WORD;
        dest_value   <= `ZERO_WORD;
        src_value    <= `ZERO_WORD;
        result_value <= `ZERO_WORD;
        zero_result  <= 1'b0;
        carry_result <= 1'b0;
        op_known     <= 1'b0;
        cond_pass    <= 1'b0;
    end else begin
        if (state == S_IDLE && write_instr)
            instr <= WDATA;
        if (state == S_READ) begin
            dest_value <= regs[dest_idx];
            src_value  <= src_operand;
            // Condition field is indexed by the flag pair; all ones runs always
            cond_pass  <= cond[{CARRY_FLAG, ZERO_FLAG}];
        end
        if (state == S_CALC) begin
            result_value <= core_result;
            zero_result  <= core_zero;
            carry_result <= core_carry;
            op_known     <= core_known;
        end
    end
end

// ---------------------------------------------
// Retire: register file and software writes
// ---------------------------------------------
// Software writes to the file are ignored while busy, so one writer at a time
always @(posedge CLOCK) begin
    if (state == S_WRITE && op_known && cond_pass && want_result)
        regs[dest_idx] <= result_value;
    else if (!BUSY && write_file)
        regs[ADDR[`IDX_W-1:0]] <= WDATA;
end

// ---------------------------------------------
// Flags
// ---------------------------------------------
// While busy, flags move only in the retire cycle, so the op sees its entry flags
always @(posedge CLOCK) begin
    if (RST) begin
        ZERO_FLAG  <= 1'b0;
        CARRY_FLAG <= 1'b0;
    end else if (state == S_WRITE) begin
        if (op_known && cond_pass && want_zero)
            ZERO_FLAG <= zero_result;
        if (op_known && cond_pass && want_carry)
            CARRY_FLAG <= carry_result;
    end else if (!BUSY && write_flags) begin
        ZERO_FLAG  <= WDATA[`FLAG_Z_BIT];
        CARRY_FLAG <= WDATA[`FLAG_C_BIT];
    end
end

// ---------------------------------------------
// Status and bookkeeping
// ---------------------------------------------
wire retire;
wire was_illegal;
wire was_skipped;
wire was_refused;

assign retire      = (state == S_WRITE);
assign was_illegal = retire & ~op_known;
assign was_skipped = retire & op_known & ~cond_pass;
assign was_refused = BUSY & (write_instr | write_file | write_flags);

// Sticky bits: a new event wins over a software clear in the same cycle
always @(posedge CLOCK) begin
    if (RST) begin
        illegal <= 1'b0;
        refused <= 1'b0;
        skipped <= 1'b0;
    end else begin
        illegal <= was_illegal
                 | (illegal & ~(write_status & WDATA[`STAT_ILLEGAL]));
        refused <= was_refused
                 | (refused & ~(write_status & WDATA[`STAT_REFUSED]));
        skipped <= was_skipped
                 | (skipped & ~(write_status & WDATA[`STAT_SKIPPED]));
    end
end

always @(posedge CLOCK) begin
    if (RST) begin
        last_result <= `ZERO_WORD;
        retired     <= `ZERO_WORD;
        DONE        <= 1'b0;
    end else begin
        DONE <= retire;
        if (retire && op_known && cond_pass)
            last_result <= result_value;
        if (retire)
            retired <= retired + {{(`DATA_W-1){1'b0}}, 1'b1};
        else if (write_count)
            retired <= `ZERO_WORD;
    end
end

// ---------------------------------------------
// Read port
// ---------------------------------------------
// Data stands one cycle after the strobe and only then
always @(posedge CLOCK) begin
    if (RST) begin
        RDATA <= `ZERO_WORD;
    end else if (READ) begin
        if (to_file) begin
            RDATA <= regs[ADDR[`IDX_W-1:0]];
        end else begin
            case (ADDR)
                `ADDR_FLAGS: begin
                    RDATA <= `ZERO_WORD;
                    RDATA[`FLAG_Z_BIT] <= ZERO_FLAG;
                    RDATA[`FLAG_C_BIT] <= CARRY_FLAG;
                end
                `ADDR_INSTR: begin
                    RDATA <= instr;
                end
                `ADDR_STATUS: begin
                    RDATA <= {{(`DATA_W-`STAT_W){1'b0}},
                              skipped, refused, illegal, BUSY};
                end
                `ADDR_LAST: begin
                    RDATA <= last_result;
                end
                `ADDR_COUNT: begin
                    RDATA <= retired;
                end
                default: begin
                    RDATA <= `ZERO_WORD;
                end
            endcase
        end
    end else begin
        RDATA <= `ZERO_WORD;
    end
end

endmodule
`default_nettype wire

/* inc/alu_defines.vh */
// How it works
// - Opcode 110011 computes destination minus (source plus carry), both unsigned, in 4 clocks.
// - Its source is a register or a 9-bit literal, chosen by the immediate bit.
// - With write-zero, zero is set only if it was already set and the difference is zero.
// - With write-carry, carry is set exactly when the subtraction borrows past bit 31.
// - Its result goes to the destination only if the result-write bit is set.
// - Opcode 100100 adds destination to minus source when carry is 1, else to source.
// - That op takes 4 clocks; zero means a zero sum, carry means signed overflow.
// - Its source is a register or 9-bit literal; the current carry picks the sign.
// - Opcode 100101 adds destination to source when carry is 1, else to minus source.
// - That op takes 4 clocks; zero means a zero sum, carry means signed overflow.
// - Its source is a register or 9-bit literal; the inverted carry picks the sign.
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// ---------------------------------------------
// Widths
// ---------------------------------------------
`define DATA_W          32
`define ADDR_W          10
`define IDX_W           9
`define ZERO_WORD       32'h0000_0000

// ---------------------------------------------
// Instruction word fields
// ---------------------------------------------
`define INSTR_OPCODE    31:26
`define BIT_UPD_Z       25
`define BIT_UPD_C       24
`define BIT_WR          23
`define BIT_IMM         22
`define INSTR_COND      21:18
`define INSTR_DEST      17:9
`define INSTR_SRC       8:0

`define OP_SUB_BORROW   6'h33
`define OP_ADD_NEG_C    6'h24
`define OP_ADD_NEG_NC   6'h25

// ---------------------------------------------
// Register port map
// ---------------------------------------------
`define ADDR_FILE_BIT   9
`define ADDR_FLAGS      10'h200
`define ADDR_INSTR      10'h201
`define ADDR_STATUS     10'h202
`define ADDR_LAST       10'h203
`define ADDR_COUNT      10'h204

`define FLAG_Z_BIT      0
`define FLAG_C_BIT      1
`define STAT_BUSY       0
`define STAT_ILLEGAL    1
`define STAT_REFUSED    2
`define STAT_SKIPPED    3
`define STAT_W          4

`endif

/* logic/literal_source_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module literal_source_select (
    input  wire                 immediate,
    input  wire [`IDX_W-1:0]    src_field,
    input  wire [`DATA_W-1:0]   reg_value,
    output wire [`DATA_W-1:0]   operand
);

// ---------------------------------------------
// Source operand
// ---------------------------------------------
// Literal is widened with zeros, never sign bits
wire [`DATA_W-1:0] literal_value;

assign literal_value = {{(`DATA_W-`IDX_W){1'b0}}, src_field};
assign operand = immediate ? literal_value : reg_value;

endmodule
`default_nettype wire

/* logic/sub_sum_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module sub_sum_core (
    input  wire [5:0]           opcode,
    input  wire [`DATA_W-1:0]   dest,
    input  wire [`DATA_W-1:0]   src,
    input  wire                 zero_in,
    input  wire                 carry_in,
    output reg  [`DATA_W-1:0]   result,
    output reg                  zero_out,
    output reg                  carry_out,
    output reg                  known
);

// ---------------------------------------------
// Arithmetic
// ---------------------------------------------
reg [`DATA_W:0] wide;
reg             negate;

always @* begin
    wide      = {(`DATA_W+1){1'b0}};
    negate    = 1'b0;
    result    = dest;
    zero_out  = zero_in;
    carry_out = carry_in;
    known     = 1'b0;
    case (opcode)
        `OP_SUB_BORROW: begin
            // Unsigned, carry is the borrow from the previous word
            wide      = {1'b0, dest} - {1'b0, src} - {{`DATA_W{1'b0}}, carry_in};
            result    = wide[`DATA_W-1:0];
            carry_out = wide[`DATA_W];
            zero_out  = zero_in & (wide[`DATA_W-1:0] == `ZERO_WORD);
            known     = 1'b1;
        end
        `OP_ADD_NEG_C, `OP_ADD_NEG_NC: begin
            if (opcode == `OP_ADD_NEG_C)
                negate = carry_in;
            else
                negate = ~carry_in;
            if (negate) begin
                result    = dest - src;
                carry_out = (dest[`DATA_W-1] ^ src[`DATA_W-1])
                          & (result[`DATA_W-1] ^ dest[`DATA_W-1]);
            end else begin
                result    = dest + src;
                carry_out = ~(dest[`DATA_W-1] ^ src[`DATA_W-1])
                          & (result[`DATA_W-1] ^ dest[`DATA_W-1]);
            end
            zero_out = (result == `ZERO_WORD);
            known    = 1'b1;
        end
        default: begin
            known = 1'b0;
        end
    endcase
end

endmodule
`default_nettype wire

/* verification/ext_sub_sum_alu_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module ext_sub_sum_alu_props (
    input wire logic                CLOCK,
    input wire logic                RST,
    input wire logic [`ADDR_W-1:0]  ADDR,
    input wire logic [`DATA_W-1:0]  WDATA,
    input wire logic                WRITE,
    input wire logic                READ,
    input wire logic [`DATA_W-1:0]  RDATA,
    input wire logic                BUSY,
    input wire logic                DONE,
    input wire logic                ZERO_FLAG,
    input wire logic                CARRY_FLAG
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    wire logic start;
    assign start = WRITE && ADDR == `ADDR_INSTR && !BUSY;

    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    busy_four_a: assert property (start |=> BUSY [*4] ##1 !BUSY)
        else $error("busy not held four cycles");
    busy_idle_a: assert property (!BUSY && !start |=> !BUSY)
        else $error("busy without a start");
    done_after_a: assert property (start |-> ##5 DONE)
        else $error("done not five cycles after start");
    done_pulse_a: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    // Flags may only move on a retire or an idle flag write
    flag_cause_a: assert property (($changed(ZERO_FLAG) || $changed(CARRY_FLAG)) |->
        DONE || $past(WRITE && ADDR == `ADDR_FLAGS && !BUSY))
        else $error("flag changed without cause");
    flags_hold_a: assert property (BUSY |-> $stable(ZERO_FLAG) && $stable(CARRY_FLAG))
        else $error("flag moved while busy");
    zero_keep_a: assert property (start && !WDATA[`BIT_UPD_Z] |=> $stable(ZERO_FLAG) [*5])
        else $error("zero changed without its write bit");
    carry_keep_a: assert property (start && !WDATA[`BIT_UPD_C] |=>
        $stable(CARRY_FLAG) [*5])
        else $error("carry changed without its write bit");
    zero_chain_a: assert property (start && WDATA[`INSTR_OPCODE] == `OP_SUB_BORROW
        && !ZERO_FLAG |-> ##5 !ZERO_FLAG)
        else $error("chained zero set from a clear zero");
    rdata_idle_a: assert property (!READ |=> RDATA == `ZERO_WORD)
        else $error("read data outside its cycle");

    cover property (start && WDATA[`INSTR_OPCODE] == `OP_SUB_BORROW ##5 DONE);
    cover property (start && WDATA[`INSTR_OPCODE] == `OP_ADD_NEG_C);
    cover property (start && WDATA[`INSTR_OPCODE] == `OP_ADD_NEG_NC);
    cover property (start && !WDATA[`BIT_WR]);
endmodule

bind ext_sub_sum_alu ext_sub_sum_alu_props u_ext_sub_sum_alu_props (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ),
    .RDATA(RDATA), .BUSY(BUSY), .DONE(DONE), .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG));
`default_nettype wire

/* verification/ext_sub_sum_alu_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module ext_sub_sum_alu_tb;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [9:0]  addr  = 10'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic        write = 1'b0;
    logic        read  = 1'b0;
    wire  [31:0] rdata;
    wire         busy, done, zf, cf;
    int          n_fail   = 0;
    int          compares = 0;

    always #4 clk = ~clk;

    ext_sub_sum_alu u_ext_sub_sum_alu (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WRITE(write), .READ(read), .RDATA(rdata), .BUSY(busy), .DONE(done),
        .ZERO_FLAG(zf), .CARRY_FLAG(cf));

    // ---------------------------------------------
    // Bus tasks
    // ---------------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        read <= 1'b1;
        @(posedge clk);
        read <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait; n is the expected count of edges seen before done
    task automatic wait_done(input int n);
        int i;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 10) begin
            $display("unexpected at %0t: no completion", $time);
            n_fail++;
            finish_test();
        end
        chk(i, n);
    endtask

    // Destination lives at word 0x010, register source at 0x011
    task automatic exe(input logic [5:0] op, input logic z, c, input logic [31:0] d, s,
                       input logic imm, upd_z, upd_c, wr_en);
        logic [32:0] full;
        logic [31:0] sv, res, q;
        logic        ez, ec, neg;
        sv = imm ? {23'h00_0000, s[8:0]} : s;
        wr(`ADDR_FLAGS, {30'h0000_0000, c, z});
        wr(10'h010, d);
        if (!imm) wr(10'h011, s);
        wr(`ADDR_INSTR, {op, upd_z, upd_c, wr_en, imm, 4'hf, 9'h010, imm ? s[8:0] : 9'h011});
        wait_done(3);
        if (op == `OP_SUB_BORROW) begin
            full = {1'b0, d} - {1'b0, sv} - {32'h0000_0000, c};
            res = full[31:0];
            ez = z && res == 32'h0000_0000;
            ec = full[32];
        end else begin
            neg = (op == `OP_ADD_NEG_C) ? c : !c;
            res = neg ? d - sv : d + sv;
            ez = res == 32'h0000_0000;
            ec = (d[31] == (sv[31] ^ neg)) && (res[31] != d[31]);
        end
        chk({zf, cf}, {upd_z ? ez : z, upd_c ? ec : c});
        rd(10'h010, q);
        chk(q, wr_en ? res : d);
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        #1;
        chk({busy, done, zf, cf}, 4'h0);
        rd(10'h3ff, q);
        chk(q, 32'h0000_0000);
    endtask

    task automatic t_borrow();
        exe(`OP_SUB_BORROW, 0, 0, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_SUB_BORROW, 1, 0, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_SUB_BORROW, 1, 1, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_SUB_BORROW, 0, 0, 32'h0000_0200, 32'h0000_01ff, 1, 1, 1, 1);
        exe(`OP_SUB_BORROW, 1, 1, 32'h0000_01ff, 32'h0000_01ff, 1, 1, 1, 1);
        // High word of a two-word chain after a borrowing low word
        exe(`OP_SUB_BORROW, 0, 1, 32'h0000_0001, 32'h0000_0000, 0, 1, 1, 1);
    endtask

    task automatic t_sums();
        exe(`OP_ADD_NEG_C, 0, 0, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_C, 0, 1, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_C, 0, 1, 32'h8000_0000, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_C, 0, 0, 32'h7fff_ffff, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_C, 0, 1, 32'h0000_0000, 32'h0000_01ff, 1, 1, 1, 1);
        exe(`OP_ADD_NEG_NC, 0, 0, 32'h0000_0001, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_NC, 0, 1, 32'h0000_0001, 32'hffff_ffff, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_NC, 0, 0, 32'h8000_0000, 32'h0000_0001, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_NC, 0, 0, 32'h7fff_ffff, 32'hffff_ffff, 0, 1, 1, 1);
        exe(`OP_ADD_NEG_NC, 1, 0, 32'h0000_0005, 32'h0000_0003, 1, 1, 1, 1);
    endtask

    task automatic t_effects();
        exe(`OP_SUB_BORROW, 1, 1, 32'h0000_0005, 32'h0000_0002, 0, 0, 0, 0);
        exe(`OP_ADD_NEG_NC, 0, 0, 32'h0000_0003, 32'h0000_0003, 0, 1, 1, 0);
        exe(`OP_ADD_NEG_C, 1, 0, 32'h7fff_ffff, 32'h0000_0001, 0, 1, 0, 1);
        exe(`OP_SUB_BORROW, 1, 0, 32'h0000_0000, 32'h0000_0001, 0, 0, 1, 1);
    endtask

    // A flag write landing mid-instruction must leave the flags alone
    task automatic t_refuse();
        wr(`ADDR_FLAGS, 32'h0000_0000);
        wr(`ADDR_INSTR, {`OP_ADD_NEG_C, 4'h1, 4'hf, 9'h010, 9'h011});
        wr(`ADDR_FLAGS, 32'h0000_0003);
        wait_done(1);
        chk({zf, cf}, 2'h0);
    endtask

    // Unknown opcode, false condition, status clearing, last result and count
    task automatic t_status();
        logic [31:0] q;
        rd(`ADDR_STATUS, q);
        chk(q, 32'h0000_0004);
        wr(`ADDR_STATUS, 32'h0000_0004);
        wr(`ADDR_COUNT, 32'h0000_0000);
        wr(`ADDR_FLAGS, 32'h0000_0000);
        wr(10'h010, 32'h1234_5678);
        wr(`ADDR_INSTR, {6'h3f, 4'hf, 4'hf, 9'h010, 9'h001});
        wait_done(3);
        chk({zf, cf}, 2'h0);
        wr(`ADDR_INSTR, {`OP_ADD_NEG_C, 4'hf, 4'h0, 9'h010, 9'h001});
        wait_done(3);
        rd(10'h010, q);
        chk(q, 32'h1234_5678);
        rd(`ADDR_STATUS, q);
        chk(q, 32'h0000_000a);
        wr(`ADDR_FLAGS, 32'h0000_0001);
        wr(`ADDR_INSTR, {`OP_ADD_NEG_C, 4'h3, 4'h2, 9'h010, 9'h001});
        wait_done(3);
        rd(10'h010, q);
        chk(q, 32'h1234_5679);
        rd(`ADDR_LAST, q);
        chk(q, 32'h1234_5679);
        rd(`ADDR_COUNT, q);
        chk(q, 32'h0000_0003);
        wr(`ADDR_STATUS, 32'h0000_000e);
        rd(`ADDR_STATUS, q);
        chk(q, 32'h0000_0000);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_borrow();
        t_sums();
        t_effects();
        t_refuse();
        t_status();
        finish_test();
    end
endmodule
`default_nettype wire
